// [design/delay_scheduler.sv]
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module delay_scheduler (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // link to trigger source and converter
  pretrig_link_if.dev LINK,
  // observation of the pretrigger chain
  output logic [pretrig_pkg::NUM_PT-1:0] PRETRIG_OUT,
  output logic LOCKED,
  output logic SEQ_ERR
);
  localparam int N = pretrig_pkg::NUM_PT;
  localparam int W = pretrig_pkg::CNT_W;
  function automatic logic [6:0] presc_limit(input logic [2:0] p);
    return 7'((8'h01 << p) - 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register writes from the link

  logic [15:0] ctrl;
  logic ldok;
  logic [W-1:0] dly [N];
  logic [W-1:0] mod_val;
  logic [W-1:0] interrupt_delay_value_val;
  logic [N-1:0] dly_wr;
  wire logic load;

  wire logic mod_wr = LINK.cfg_we && (LINK.cfg_addr == pretrig_pkg::REG_MOD);
  wire logic interrupt_delay_value_wr = LINK.cfg_we && (LINK.cfg_addr == pretrig_pkg::REG_INTERRUPT_DELAY_VALUE);
  wire logic ctrl_wr = LINK.cfg_we && (LINK.cfg_addr == pretrig_pkg::REG_CTRL);
  wire logic cmd_wr = LINK.cfg_we && (LINK.cfg_addr == pretrig_pkg::REG_CMD);
  wire logic ldok_wr = cmd_wr && LINK.cfg_wdata[pretrig_pkg::CMD_LDOK_BIT];
  wire logic sw_trig = cmd_wr && LINK.cfg_wdata[pretrig_pkg::CMD_SWTRIG_BIT];

  // each pretrigger delay written on its own index
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_dly
      assign dly_wr[gi] = LINK.cfg_we
        && (LINK.cfg_addr == 4'(pretrig_pkg::REG_DLY0 + 4'(gi)));
      double_buffer_reg #(
        .W(W),
        .RESET_VAL((gi == 0) ? pretrig_pkg::DLY_OFFSET_RESET :
                   (gi == 3) ? pretrig_pkg::DLY_BUS_RESET :
                   pretrig_pkg::DLY_OTHER_RESET)
      ) u_dly (
        .clk(CLK),
        .rstn(RSTN),
        .wr(dly_wr[gi]),
        .wdata(LINK.cfg_wdata),
        .load(load),
        .active(dly[gi])
      );
    end
  endgenerate

  double_buffer_reg #(
    .W(W),
    .RESET_VAL(pretrig_pkg::MOD_RESET)
  ) u_mod (
    .clk(CLK),
    .rstn(RSTN),
    .wr(mod_wr),
    .wdata(LINK.cfg_wdata),
    .load(load),
    .active(mod_val)
  );

  double_buffer_reg #(
    .W(W),
    .RESET_VAL(pretrig_pkg::INTERRUPT_DELAY_VALUE_RESET)
  ) u_interrupt_delay_value (
    .clk(CLK),
    .rstn(RSTN),
    .wr(interrupt_delay_value_wr),
    .wdata(LINK.cfg_wdata),
    .load(load),
    .active(interrupt_delay_value_val)
  );

  // control is not buffered: it takes effect on the write
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= pretrig_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= LINK.cfg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration fields

  wire logic [2:0] presc = ctrl[pretrig_pkg::CTRL_PRESC_LSB +: pretrig_pkg::PRESC_W];
  wire pretrig_pkg::trig_sel_e tsel =
    pretrig_pkg::trig_sel_e'(ctrl[pretrig_pkg::CTRL_TSEL_LSB +: 2]);
  wire pretrig_pkg::load_mode_e ldmode =
    pretrig_pkg::load_mode_e'(ctrl[pretrig_pkg::CTRL_LDMODE_LSB +: 2]);
  wire logic [N-1:0] pt_en = ctrl[pretrig_pkg::CTRL_PTEN_LSB +: N];
  wire logic cont = ctrl[pretrig_pkg::CTRL_CONT_BIT];
  wire logic enable = ctrl[pretrig_pkg::CTRL_EN_BIT];

  wire logic trig_hit = (tsel == pretrig_pkg::TSEL_IN0) ? LINK.trig[0] :
                        (tsel == pretrig_pkg::TSEL_IN1) ? LINK.trig[1] :
                        (tsel == pretrig_pkg::TSEL_SW) ? sw_trig : 1'b0;
  wire logic trig_acc = enable && trig_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // delay counter

  logic run;
  logic fresh;
  logic [W-1:0] cnt;
  logic [6:0] presc_cnt;

  wire logic tick = (presc_cnt == presc_limit(presc));
  wire logic at_mod = (cnt == mod_val);
  wire logic mod_end = run && tick && at_mod && !trig_acc;

  // counter ticks once every 2^presc CLK cycles, from the same CLK as the pwm timer
  // fresh marks a new count value so each value matches once
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      run <= 1'b0;
      fresh <= 1'b0;
      cnt <= '0;
      presc_cnt <= 7'h00;
    end else if (trig_acc) begin
      run <= 1'b1;
      fresh <= 1'b1;
      cnt <= '0;
      presc_cnt <= 7'h00;
    end else if (!enable || !run) begin
      run <= 1'b0;
      fresh <= 1'b0;
      presc_cnt <= 7'h00;
    end else if (tick) begin
      presc_cnt <= 7'h00;
      fresh <= !at_mod || cont;
      run <= !at_mod || cont;
      cnt <= at_mod ? '0 : W'(cnt + 1'b1);
    end else begin
      fresh <= 1'b0;
      presc_cnt <= 7'(presc_cnt + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffered register transfer

  wire logic load_evt = (ldmode == pretrig_pkg::LOAD_AT_MOD) ? mod_end :
                        (ldmode == pretrig_pkg::LOAD_AT_TRIG) ? trig_acc :
                        (ldmode == pretrig_pkg::LOAD_AT_EITHER) ? (mod_end || trig_acc) :
                        1'b0;
  assign load = (ldmode == pretrig_pkg::LOAD_NOW) ? ldok_wr : (ldok && load_evt);
  wire logic ldok_set = ldok_wr && (ldmode != pretrig_pkg::LOAD_NOW);

  // a new load request in the load cycle stays armed
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ldok <= 1'b0;
    end else begin
      ldok <= ldok_set || (ldok && !load);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pretrigger sequencing

  pretrig_pkg::seq_state_e state;
  pretrig_pkg::seq_state_e next_state;
  logic [N-1:0] pending;
  logic [N-1:0] next_pending;
  logic [N-1:0] pretrig;
  logic [N-1:0] next_pretrig;
  logic [2:0] cur;
  logic [2:0] next_cur;
  logic seq_err;
  logic delay_int;
  logic [N-1:0] match;

  generate
    for (gi = 0; gi < N; gi++) begin : g_match
      assign match[gi] = fresh && run && pt_en[gi] && (cnt == dly[gi]);
    end
  endgenerate
  wire logic locked = (state == pretrig_pkg::SEQ_LOCKED);
  wire logic [N-1:0] avail = pending | match;
  wire logic [2:0] issue_idx = pretrig_pkg::lowest_index(avail);
  wire logic [N-1:0] issue_oh = N'(1) << issue_idx;
  wire logic multi = |(match & (match - N'(1)));
  // a trigger while still locked means the chain stalled; flag it too
  wire logic seq_hit = ((|match) && (locked || (|pending) || multi))
                       || (trig_acc && locked);
  wire logic done_cur = LINK.conv_done[cur];
  always_comb begin
    next_state = state;
    next_pending = avail;
    next_cur = cur;
    next_pretrig = '0;
    case (state)
      pretrig_pkg::SEQ_IDLE: begin
        if (|avail) begin
          next_state = pretrig_pkg::SEQ_LOCKED;
          next_cur = issue_idx;
          next_pretrig = issue_oh;
          next_pending = avail & ~issue_oh;
        end
      end
      pretrig_pkg::SEQ_LOCKED: begin
        if (done_cur) begin
          next_state = pretrig_pkg::SEQ_IDLE;
        end
      end
      default: begin
        next_state = pretrig_pkg::SEQ_IDLE;
      end
    endcase
    // a new period frees a blocked chain rather than hanging forever
    if (trig_acc) begin
      next_state = pretrig_pkg::SEQ_IDLE;
      next_pending = '0;
      next_pretrig = '0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= pretrig_pkg::SEQ_IDLE;
      pending <= '0;
      pretrig <= '0;
      cur <= 3'h0;
      seq_err <= 1'b0;
      delay_int <= 1'b0;
    end else begin
      state <= next_state;
      pending <= next_pending;
      pretrig <= next_pretrig;
      cur <= next_cur;
      seq_err <= seq_hit;
      delay_int <= fresh && run && (cnt == interrupt_delay_value_val);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign LINK.pretrig = pretrig;
  assign LINK.seq_err = seq_err;
  assign LINK.delay_int = delay_int;
  assign LINK.count = cnt;
  assign LINK.busy = run;
  assign PRETRIG_OUT = pretrig;
  assign LOCKED = locked;
  assign SEQ_ERR = seq_err;
endmodule

// [design/double_buffer_reg.sv]
`timescale 1ns/1ps
module double_buffer_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // buffer write and transfer
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic load,
  // value in use
  output logic [W-1:0] active
);
  logic [W-1:0] buffer;

  // a write in the load cycle waits for the next load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buffer <= RESET_VAL;
      active <= RESET_VAL;
    end else begin
      if (wr) begin
        buffer <= wdata;
      end
      if (load) begin
        active <= buffer;
      end
    end
  end
endmodule

// [design/pretrig_link_if.sv]
`timescale 1ns/1ps
interface pretrig_link_if;
  logic [1:0] trig;
  logic cfg_we;
  logic [pretrig_pkg::CFG_AW-1:0] cfg_addr;
  logic [15:0] cfg_wdata;
  logic [pretrig_pkg::NUM_PT-1:0] pretrig;
  logic [pretrig_pkg::NUM_PT-1:0] conv_done;
  logic seq_err;
  logic delay_int;
  logic [pretrig_pkg::CNT_W-1:0] count;
  logic busy;

  modport dev (
    input trig, cfg_we, cfg_addr, cfg_wdata, conv_done,
    output pretrig, seq_err, delay_int, count, busy
  );
  modport ctl (
    output trig, cfg_we, cfg_addr, cfg_wdata, conv_done,
    input pretrig, seq_err, delay_int, count, busy
  );
endinterface

// [design/pretrig_pkg.sv]
package pretrig_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes and timing
  localparam int NUM_PT = 6;
  localparam int CNT_W = 16;
  localparam int CFG_AW = 4;
  localparam int CLK_PERIOD_NS = 10;
  // converter busy time per channel; a least time, so it rounds up
  localparam int CONV_TIME_NS = 1250;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // software control cycle
  localparam int CTRL_CYCLE_NS = 100000;
  localparam int CTRL_CYCLE_CYCLES = CTRL_CYCLE_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // scheduler register indices on the link
  localparam logic [3:0] REG_DLY0 = 4'h0;
  localparam logic [3:0] REG_MOD = 4'h6;
  localparam logic [3:0] REG_INTERRUPT_DELAY_VALUE = 4'h7;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_CMD = 4'h9;

  // control register fields
  localparam int CTRL_PRESC_LSB = 0;
  localparam int PRESC_W = 3;
  localparam int CTRL_TSEL_LSB = 3;
  localparam int CTRL_LDMODE_LSB = 5;
  localparam int CTRL_PTEN_LSB = 7;
  localparam int CTRL_CONT_BIT = 13;
  localparam int CTRL_EN_BIT = 14;
  localparam int CMD_LDOK_BIT = 0;
  localparam int CMD_SWTRIG_BIT = 1;

  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] MOD_RESET = 16'h1f3f;
  localparam logic [15:0] INTERRUPT_DELAY_VALUE_RESET = 16'h0000;
  localparam logic [15:0] DLY_OFFSET_RESET = 16'h0000;
  localparam logic [15:0] DLY_BUS_RESET = 16'h07d0;
  localparam logic [15:0] DLY_OTHER_RESET = 16'h0000;

  typedef enum logic [1:0] {
    LOAD_NOW = 2'b00,
    LOAD_AT_MOD = 2'b01,
    LOAD_AT_TRIG = 2'b10,
    LOAD_AT_EITHER = 2'b11
  } load_mode_e;

  typedef enum logic [1:0] {
    TSEL_IN0 = 2'b00,
    TSEL_IN1 = 2'b01,
    TSEL_SW = 2'b10,
    TSEL_NONE = 2'b11
  } trig_sel_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_LOCKED = 1'b1
  } seq_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // controller register word offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PWM_MOD = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_CLEAR = 4'h3;
  localparam logic [3:0] OFS_ENABLE = 4'h4;
  localparam logic [3:0] OFS_MONITOR = 4'h5;
  localparam logic [3:0] OFS_DEV_ADDR = 4'h6;
  localparam logic [3:0] OFS_DEV_DATA = 4'h7;
  localparam int HCTRL_PWM_EN_BIT = 0;
  localparam int HCTRL_SWTRIG_BIT = 1;
  localparam int EV_W = 3;
  localparam int EV_SEQERR = 0;
  localparam int EV_DELAY = 1;
  localparam int EV_CYCLE = 2;
  localparam logic [15:0] PWM_MOD_RESET = 16'h1f3f;

  // lowest set bit wins, so equal delays go out in channel order
  function automatic logic [2:0] lowest_index(input logic [NUM_PT-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_PT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

endpackage

// [design/trigger_controller.sv]
`timescale 1ns/1ps
module trigger_controller #(
  parameter int CTRL_CYCLES = pretrig_pkg::CTRL_CYCLE_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // avalon-mm slave, word addressed
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // interrupt
  output logic IRQ,
  // link to the scheduler
  pretrig_link_if.ctl LINK
);
  localparam int N = pretrig_pkg::NUM_PT;
  localparam int EW = pretrig_pkg::EV_W;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle per access

  logic ack;
  logic pwm_en;
  logic [15:0] pwm_mod;
  logic [EW-1:0] status;
  logic [EW-1:0] enable;
  logic [3:0] dev_addr;
  logic [31:0] rdata;

  wire logic req = AVS_READ || AVS_WRITE;
  wire logic wr_take = AVS_WRITE && ack;
  wire logic wr_ctrl = wr_take && (AVS_ADDRESS == pretrig_pkg::OFS_CTRL);
  wire logic wr_clear = wr_take && (AVS_ADDRESS == pretrig_pkg::OFS_CLEAR);
  wire logic [31:0] rd_mux =
    (AVS_ADDRESS == pretrig_pkg::OFS_CTRL) ? {31'h0, pwm_en} :
    (AVS_ADDRESS == pretrig_pkg::OFS_PWM_MOD) ? {16'h0, pwm_mod} :
    (AVS_ADDRESS == pretrig_pkg::OFS_STATUS) ? {29'h0, status} :
    (AVS_ADDRESS == pretrig_pkg::OFS_ENABLE) ? {29'h0, enable} :
    (AVS_ADDRESS == pretrig_pkg::OFS_MONITOR) ? {15'h0, LINK.busy, LINK.count} :
    (AVS_ADDRESS == pretrig_pkg::OFS_DEV_ADDR) ? {28'h0, dev_addr} : 32'h0;

  assign AVS_WAITREQUEST = req && !ack;
  assign AVS_READDATA = rdata;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack <= 1'b0;
      rdata <= 32'h0;
    end else begin
      ack <= req && !ack;
      if (AVS_READ && !ack) begin
        rdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwm_en <= 1'b0;
      pwm_mod <= pretrig_pkg::PWM_MOD_RESET;
      enable <= '0;
      dev_addr <= 4'h0;
    end else if (wr_take) begin
      case (AVS_ADDRESS)
        pretrig_pkg::OFS_CTRL: pwm_en <= AVS_WRITEDATA[pretrig_pkg::HCTRL_PWM_EN_BIT];
        pretrig_pkg::OFS_PWM_MOD: pwm_mod <= AVS_WRITEDATA[15:0];
        pretrig_pkg::OFS_ENABLE: enable <= AVS_WRITEDATA[EW-1:0];
        pretrig_pkg::OFS_DEV_ADDR: dev_addr <= AVS_WRITEDATA[3:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scheduler writes: software reloads dynamic delays here

  logic cfg_we;
  logic [3:0] cfg_addr;
  logic [15:0] cfg_wdata;
  logic sw_trig;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_we <= 1'b0;
      cfg_addr <= 4'h0;
      cfg_wdata <= 16'h0;
      sw_trig <= 1'b0;
    end else begin
      cfg_we <= wr_take && (AVS_ADDRESS == pretrig_pkg::OFS_DEV_DATA);
      sw_trig <= wr_ctrl && AVS_WRITEDATA[pretrig_pkg::HCTRL_SWTRIG_BIT];
      if (wr_take && (AVS_ADDRESS == pretrig_pkg::OFS_DEV_DATA)) begin
        cfg_addr <= dev_addr;
        cfg_wdata <= AVS_WRITEDATA[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pwm period timer on the shared clock, start-of-period trigger

  logic [15:0] pwm_cnt;
  logic pwm_trig;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwm_cnt <= 16'h0;
      pwm_trig <= 1'b0;
    end else if (!pwm_en) begin
      pwm_cnt <= 16'h0;
      pwm_trig <= 1'b0;
    end else begin
      pwm_trig <= (pwm_cnt == 16'h0);
      pwm_cnt <= (pwm_cnt == pwm_mod) ? 16'h0 : 16'(pwm_cnt + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter: busy for the conversion time, then one done pulse

  logic conv_busy;
  logic [7:0] conv_cnt;
  logic [2:0] conv_ch;
  logic [N-1:0] conv_done;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      conv_busy <= 1'b0;
      conv_cnt <= 8'h0;
      conv_ch <= 3'h0;
      conv_done <= '0;
    end else begin
      conv_done <= '0;
      if (conv_busy) begin
        conv_cnt <= 8'(conv_cnt - 1'b1);
        if (conv_cnt == 8'h0) begin
          conv_busy <= 1'b0;
          conv_done <= N'(1) << conv_ch;
        end
      end else if (|LINK.pretrig) begin
        conv_busy <= 1'b1;
        conv_ch <= pretrig_pkg::lowest_index(LINK.pretrig);
        conv_cnt <= 8'(pretrig_pkg::CONV_CYCLES - 1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control cycle tick and interrupts

  logic [31:0] cyc_cnt;
  logic cyc_evt;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cyc_cnt <= 32'h0;
      cyc_evt <= 1'b0;
    end else begin
      cyc_evt <= (cyc_cnt == 32'(CTRL_CYCLES - 1));
      cyc_cnt <= (cyc_cnt == 32'(CTRL_CYCLES - 1)) ? 32'h0 : 32'(cyc_cnt + 1'b1);
    end
  end

  wire logic [EW-1:0] ev = {cyc_evt, LINK.delay_int, LINK.seq_err};
  wire logic [EW-1:0] clr = wr_clear ? AVS_WRITEDATA[EW-1:0] : '0;

  // an event in the clear cycle survives the clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | ev;
    end
  end

  assign IRQ = |(status & enable);
  assign LINK.trig = {sw_trig, pwm_trig};
  assign LINK.cfg_we = cfg_we;
  assign LINK.cfg_addr = cfg_addr;
  assign LINK.cfg_wdata = cfg_wdata;
  assign LINK.conv_done = conv_done;
endmodule

// [testbench/pretrig_properties.sv]
`timescale 1ns/1ps
module pretrig_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // link signals
  input wire logic [1:0] trig,
  input wire logic cfg_we,
  input wire logic [pretrig_pkg::NUM_PT-1:0] pretrig,
  input wire logic [pretrig_pkg::NUM_PT-1:0] conv_done,
  input wire logic [pretrig_pkg::CNT_W-1:0] count,
  input wire logic busy
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_issue;
    pretrig != '0;
  endsequence
  // converter answer window; a hung chain shows up here
  sequence s_done;
    ##[100:140] (conv_done != '0);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_pretrig_onehot: assert property ($onehot0(pretrig))
    else $error("more than one pretrigger at once");
  a_pretrig_pulse: assert property (s_issue |=> pretrig == '0)
    else $error("pretrigger longer than one cycle");
  a_lock_held: assert property (s_issue |=> (pretrig == '0) until (conv_done != '0))
    else $error("pretrigger issued while locked");
  a_conv_bounded: assert property (s_issue |-> s_done)
    else $error("no conversion done in time");
  a_done_gap: assert property (conv_done != '0 |=> pretrig == '0)
    else $error("pretrigger right after conversion done");
  a_count_restart: assert property ($rose(busy) |-> count == '0)
    else $error("counter not restarted from zero");
  a_done_onehot: assert property ($onehot0(conv_done))
    else $error("more than one conversion done");
  a_cfg_strobe: assert property (cfg_we |=> !cfg_we)
    else $error("config strobe longer than one cycle");
  a_trig_pulse: assert property (trig != 2'b00 |=> trig == 2'b00)
    else $error("trigger longer than one cycle");
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic irq;
  logic [pretrig_pkg::NUM_PT-1:0] pt_out;
  logic locked;
  logic seq_err;
  logic [31:0] rd;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int dn_cnt = 0;
  int lk_cnt = 0;
  int se_cnt = 0;
  int pt_q[$];
  int st_q[$];
  int dly[6] = '{0, 300, 600, 2000, 2300, 2600};

  pretrig_link_if link();
  always #5 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////////
  delay_scheduler i_delay_scheduler (.CLK(CLK), .RSTN(RSTN), .LINK(link.dev),
    .PRETRIG_OUT(pt_out), .LOCKED(locked), .SEQ_ERR(seq_err));
  // short control cycle keeps the run brief
  trigger_controller #(.CTRL_CYCLES(200)) i_trigger_controller (.CLK(CLK), .RSTN(RSTN),
    .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata),
    .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .IRQ(irq), .LINK(link.ctl));
  pretrig_properties i_pretrig_properties (.CLK(CLK), .RSTN(RSTN), .trig(link.trig),
    .cfg_we(link.cfg_we), .pretrig(link.pretrig), .conv_done(link.conv_done),
    .count(link.count), .busy(link.busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic av_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= 1'b1;
    do @(posedge CLK); while (av_wait !== 1'b0);
    av_wr <= 1'b0;
  endtask

  task automatic av_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK);
    av_addr <= a;
    av_rd <= 1'b1;
    do @(posedge CLK); while (av_wait !== 1'b0);
    d = av_rdata;
    av_rd <= 1'b0;
  endtask

  task automatic dev_wr(input logic [3:0] idx, input logic [15:0] val);
    av_write(pretrig_pkg::OFS_DEV_ADDR, {28'h0, idx});
    av_write(pretrig_pkg::OFS_DEV_DATA, {16'h0, val});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // stamps every pretrigger; also the watchdog
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++) begin
      if (pt_out[i] === 1'b1) begin
        pt_q.push_back(i);
        st_q.push_back(cyc);
      end
      if (link.conv_done[i] === 1'b1) begin
        dn_cnt <= dn_cnt + 1;
      end
    end
    if (locked === 1'b1) begin
      lk_cnt <= lk_cnt + 1;
    end
    if (seq_err === 1'b1) begin
      se_cnt <= se_cnt + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    av_read(pretrig_pkg::OFS_PWM_MOD, rd);
    check(rd, {16'h0, pretrig_pkg::PWM_MOD_RESET});
    av_read(4'hf, rd);
    check(rd, 32'h0);
    // full chain, software trigger source
    for (int i = 0; i < 6; i++) begin
      dev_wr(pretrig_pkg::REG_DLY0 + 4'(i), 16'(dly[i]));
    end
    dev_wr(pretrig_pkg::REG_CTRL, 16'h5f90);
    dev_wr(pretrig_pkg::REG_CMD, 16'h0001);
    dev_wr(pretrig_pkg::REG_CMD, 16'h0002);
    wait (dn_cnt == 6);
    check(pt_q.size(), 6);
    for (int i = 0; i < 6; i++) begin
      check(pt_q[i], i);
      check(st_q[i] - st_q[0], dly[i]);
    end
    av_read(pretrig_pkg::OFS_STATUS, rd);
    check(rd & 32'h1, 32'h0);
    check(lk_cnt, 6 * (pretrig_pkg::CONV_CYCLES + 2));
    check(se_cnt, 0);
    // equal delays on two channels, trigger input one
    pt_q.delete();
    st_q.delete();
    av_write(pretrig_pkg::OFS_CLEAR, 32'h7);
    dev_wr(4'h1, 16'h0064);
    dev_wr(4'h2, 16'h0064);
    dev_wr(pretrig_pkg::REG_CTRL, 16'h4308);
    dev_wr(pretrig_pkg::REG_CMD, 16'h0001);
    av_write(pretrig_pkg::OFS_CTRL, 32'h2);
    wait (dn_cnt == 8);
    check(pt_q[0], 1);
    check(pt_q[1], 2);
    check(st_q[1] - st_q[0], pretrig_pkg::CONV_CYCLES + 3);
    check(se_cnt, 1);
    av_read(pretrig_pkg::OFS_STATUS, rd);
    check(rd & 32'h1, 32'h1);
    check(irq, 1'b0);
    av_write(pretrig_pkg::OFS_ENABLE, 32'h1);
    @(posedge CLK);
    check(irq, 1'b1);
    av_write(pretrig_pkg::OFS_CLEAR, 32'h1);
    @(posedge CLK);
    check(irq, 1'b0);
    av_read(pretrig_pkg::OFS_STATUS, rd);
    check(rd & 32'h1, 32'h0);
    // pwm timer trigger, divide by two, load at trigger, continuous count
    pt_q.delete();
    st_q.delete();
    dev_wr(pretrig_pkg::REG_MOD, 16'h0063);
    dev_wr(pretrig_pkg::REG_INTERRUPT_DELAY_VALUE, 16'h0010);
    dev_wr(pretrig_pkg::REG_CTRL, 16'h60c1);
    dev_wr(pretrig_pkg::REG_CMD, 16'h0001);
    av_write(pretrig_pkg::OFS_CLEAR, 32'h7);
    av_write(pretrig_pkg::OFS_PWM_MOD, 32'h18f);
    av_write(pretrig_pkg::OFS_CTRL, 32'h1);
    wait (dn_cnt == 11);
    check(pt_q.size(), 3);
    check(pt_q[2], 0);
    // two clocks per tick, modulus 99: one offset sample every 200 clocks
    check(st_q[1] - st_q[0], 200);
    check(st_q[2] - st_q[1], 200);
    av_read(pretrig_pkg::OFS_MONITOR, rd);
    check(rd[16], 1'b1);
    check(rd[15:0] <= 16'h0063, 1);
    av_read(pretrig_pkg::OFS_STATUS, rd);
    check(rd & 32'h7, 32'h6);
    complete_run();
  end
endmodule
